// ==== src/mem_inject_regs.svh ====
/*
  Register offsets, field positions and reset values of the memory error injection block.
  Assumes a byte-addressed configuration port carrying aligned 32-bit dwords with byte enables.
*/
`ifndef MEM_INJECT_REGS_SVH
`define MEM_INJECT_REGS_SVH

// Printed byte offsets of the configuration registers.
`define OFS_MASK_A         12'h100
`define OFS_MASK_B         12'h104
`define OFS_MASK_B_ALT     12'h106
`define OFS_MASK_A_ALT     12'h108
`define OFS_CHAN_CTL_LO    12'h10c
`define OFS_STUCK_LO       12'h111
`define OFS_CHAN_CTL_HI    12'h20c
`define OFS_STUCK_HI       12'h211

// Channel inject control fields.
`define CTL_EN_HI          23
`define CTL_EN_LO          22
`define CTL_SEL_BIT        21
`define CTL_CMD_HI         20
`define CTL_CMD_LO         18
`define CTL_OP_HI          17
`define CTL_OP_LO          14
`define CTL_FLIT_HI        13
`define CTL_FLIT_LO        10
`define CTL_BITS_HI        9
`define CTL_BITS_LO        0
`define CTL_WR_MASK        32'h00ff_ffff
`define CTL_RESET          32'h0000_0000

// Stuck lane select fields.
`define STUCK_HI           3
`define STUCK_LO           0
`define STUCK_WR_MASK      8'h0f
`define STUCK_RESET        8'h0f
`define STUCK_LAST_LANE    4'h9

// Memory mask A fields.
`define MSKA_HALF_HI       29
`define MSKA_HALF_LO       28
`define MSKA_EN_BIT        27
`define MSKA_SEL_BIT       26
`define MSKA_PH2_HI        25
`define MSKA_PH2_LO        18
`define MSKA_PH1_HI        17
`define MSKA_PH1_LO        10
`define MSKA_POS2_HI       9
`define MSKA_POS2_LO       5
`define MSKA_POS1_HI       4
`define MSKA_POS1_LO       0
`define MSKA_WR_MASK       32'h3fff_ffff
`define MSKA_RESET         32'h1000_0000

// Memory mask B fields.
`define MSKB_PH2_HI        15
`define MSKB_PH2_LO        8
`define MSKB_PH1_HI        7
`define MSKB_PH1_LO        0
`define MSKB_RESET         16'h0000

// Flit and device limits.
`define FLIT_LAST          4'hb
`define DEV_COUNT          18
`define DEV_LAST           5'h11

`endif

// ==== src/mem_inject_pkg.sv ====
/*
  Types of the memory error injection block: modes, command kinds and traffic carriers.
  Assumes the constants header is included by the design file.
*/
package mem_inject_pkg;

  typedef enum logic [1:0] {
    CH_INJ_OFF   = 2'b00,
    CH_INJ_FLIT  = 2'b01,
    CH_INJ_STUCK = 2'b10,
    CH_INJ_RSVD  = 2'b11
  } chan_mode_e;

  typedef enum logic [2:0] {
    CMD_BY_OPCODE = 3'b000,
    CMD_PRE_ALL   = 3'b001,
    CMD_READ      = 3'b010,
    CMD_WRITE     = 3'b011
  } cmd_kind_e;

  typedef enum logic [1:0] {
    HALF_RSVD  = 2'b00,
    HALF_LOWER = 2'b01,
    HALF_UPPER = 2'b10,
    HALF_BOTH  = 2'b11
  } half_sel_e;

  // One southbound flit beat on a channel, with the two response-function triggers.
  typedef struct packed {
    logic       valid;
    logic       resp_a;
    logic       resp_b;
    logic [2:0] cmd_kind;
    logic [3:0] opcode;
    logic [3:0] flit_idx;
    logic [9:0] lanes;
  } flit_s;

  // One data phase of a cache-line transfer on a branch, ahead of ECC checking.
  typedef struct packed {
    logic         valid;
    logic         resp_a;
    logic         resp_b;
    logic [1:0]   xfer;
    logic         phase;
    logic [143:0] data;
  } beat_s;

endpackage

// ==== src/memory_error_injection.sv ====
/*
  Memory error injection: corrupts outbound channel flits, sticks a southbound lane at one,
  and XORs masks into two x8 device locations of cache-line data on two branches.
  Assumes a single core clock, traffic synchronous to it, and config accesses of one cycle.
*/
// Functional notes
// - Channel mode: 00 none, 01 flit corruption, 10 stuck lane, 11 reserved.
// - Channel select bit picks response function a or b as trigger.
// - Command type: 000 opcode, 001 precharge all, 010 read, 011 write.
// - With command type 000 only commands whose opcode matches get corrupted.
// - Flit number 0 to 11 picks the corrupted flit; 12 to 15 reserved.
// - Ten bit-position bits flip lanes in the chosen flit; several give multi-bit errors.
// - Stuck mode drives the selected southbound lane to constant one.
// - Lane values 0 to 9 select lanes; above 9, including reset, do nothing.
// - Equal first and second locations: only the first mask corrupts data.
// - Both masks apply once enabled unless both locations are equal; software zeroes a mask to neutralise it.
// - Half-line 01 lower transfers, 10 upper, 11 both, 00 reserved.
// - Memory enable bit turns memory injection off or on.
// - Memory function-select bit picks response function a or b as trigger.
// - First mask upper byte hits phase two, lower byte phase one.
// - Two five-bit fields pick first and second device positions 0 to 17.
// - Second mask upper byte hits phase two, lower byte phase one, second device.
`timescale 1ns/1ps
`include "mem_inject_regs.svh"

module memory_error_injection
  import mem_inject_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [11:0] cfg_addr,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  input  wire flit_s       chan_in  [2],
  output flit_s            chan_out [2],
  input  wire beat_s       mem_in   [2],
  output beat_s            mem_out  [2]
);

  // Byte addresses of the registers, taken from the constants header.
  localparam logic [11:0] A_MSKA   = `OFS_MASK_A;
  localparam logic [11:0] A_MSKB   = `OFS_MASK_B;
  localparam logic [11:0] A_MSKB_A = `OFS_MASK_B_ALT;
  localparam logic [11:0] A_MSKA_A = `OFS_MASK_A_ALT;
  localparam logic [11:0] A_CTL_LO = `OFS_CHAN_CTL_LO;
  localparam logic [11:0] A_STK_LO = `OFS_STUCK_LO;
  localparam logic [11:0] A_CTL_HI = `OFS_CHAN_CTL_HI;
  localparam logic [11:0] A_STK_HI = `OFS_STUCK_HI;

  // Configuration registers; index 0 is the low set (0x10c, 0x111, branch with mask A at 0x100).
  logic [31:0] ctl_q   [2];
  logic [7:0]  stuck_q [2];
  logic [31:0] mska_q  [2];
  logic [15:0] mskb_q  [2];

  // Registered read answer.
  logic [31:0] rdata_q;
  logic        rvalid_q;

  // Output registers of the channel and memory paths.
  flit_s       flit_q  [2];
  beat_s       beat_q  [2];

  // Byte-lane merge of a dword write into the old value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Dword address decode; both mask B registers share one dword and the stuck selects sit in byte 1.
  wire [9:0] dw       = cfg_addr[11:2];
  wire       hit_mska = dw == A_MSKA[11:2];
  wire       hit_mskb = dw == A_MSKB[11:2];
  wire       hit_maa  = dw == A_MSKA_A[11:2];
  wire       hit_c_lo = dw == A_CTL_LO[11:2];
  wire       hit_c_hi = dw == A_CTL_HI[11:2];
  wire       hit_s_lo = dw == A_STK_LO[11:2];
  wire       hit_s_hi = dw == A_STK_HI[11:2];
  wire [1:0] lb_b     = A_MSKB[1:0];
  wire [1:0] lb_ba    = A_MSKB_A[1:0];
  wire [1:0] lb_slo   = A_STK_LO[1:0];
  wire [1:0] lb_shi   = A_STK_HI[1:0];

  // Read data mux; unmapped dwords and reserved bits read as zero.
  wire [31:0] dw_mskb = ({16'h0000, mskb_q[1]} << {lb_b, 3'b000}) | ({16'h0000, mskb_q[0]} << {lb_ba, 3'b000});
  wire [31:0] dw_slo  = {24'h000000, stuck_q[0]} << {lb_slo, 3'b000};
  wire [31:0] dw_shi  = {24'h000000, stuck_q[1]} << {lb_shi, 3'b000};
  wire [31:0] rd_mux  = hit_mska ? mska_q[0] :
                        hit_maa  ? mska_q[1] :
                        hit_mskb ? dw_mskb :
                        hit_c_lo ? ctl_q[0] :
                        hit_c_hi ? ctl_q[1] :
                        hit_s_lo ? dw_slo :
                        hit_s_hi ? dw_shi : 32'h0000_0000;

  // Merged write values, masked to the writable fields.
  wire [31:0] w_mska  = merge(mska_q[0], cfg_wdata, cfg_be) & `MSKA_WR_MASK;
  wire [31:0] w_maa   = merge(mska_q[1], cfg_wdata, cfg_be) & `MSKA_WR_MASK;
  wire [31:0] w_mskb  = merge(dw_mskb, cfg_wdata, cfg_be);
  wire [31:0] w_c_lo  = merge(ctl_q[0], cfg_wdata, cfg_be) & `CTL_WR_MASK;
  wire [31:0] w_c_hi  = merge(ctl_q[1], cfg_wdata, cfg_be) & `CTL_WR_MASK;
  wire [31:0] w_s_lo  = merge(dw_slo, cfg_wdata, cfg_be) >> {lb_slo, 3'b000};
  wire [31:0] w_s_hi  = merge(dw_shi, cfg_wdata, cfg_be) >> {lb_shi, 3'b000};
  wire [31:0] w_b1    = w_mskb >> {lb_b, 3'b000};
  wire [31:0] w_b0    = w_mskb >> {lb_ba, 3'b000};

  // Write strobes of each register, qualified by the dword decode.
  wire       we_mska = cfg_wr && hit_mska;
  wire       we_maa  = cfg_wr && hit_maa;
  wire       we_mskb = cfg_wr && hit_mskb;
  wire       we_c_lo = cfg_wr && hit_c_lo;
  wire       we_c_hi = cfg_wr && hit_c_hi;
  wire       we_s_lo = cfg_wr && hit_s_lo;
  wire       we_s_hi = cfg_wr && hit_s_hi;

  // Stuck select next values; the reserved upper nibble stays zero.
  wire [7:0] s_lo_d  = w_s_lo[7:0] & `STUCK_WR_MASK;
  wire [7:0] s_hi_d  = w_s_hi[7:0] & `STUCK_WR_MASK;

  // Channel control of the low set, read by channel 0.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q[0] <= `CTL_RESET;
    end else if (we_c_lo) begin
      ctl_q[0] <= w_c_lo;
    end
  end

  // Channel control of the high set, read by channel 1.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q[1] <= `CTL_RESET;
    end else if (we_c_hi) begin
      ctl_q[1] <= w_c_hi;
    end
  end

  // Stuck lane select of the low set.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stuck_q[0] <= `STUCK_RESET;
    end else if (we_s_lo) begin
      stuck_q[0] <= s_lo_d;
    end
  end

  // Stuck lane select of the high set.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stuck_q[1] <= `STUCK_RESET;
    end else if (we_s_hi) begin
      stuck_q[1] <= s_hi_d;
    end
  end

  // Mask A of branch 0.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mska_q[0] <= `MSKA_RESET;
    end else if (we_mska) begin
      mska_q[0] <= w_mska;
    end
  end

  // Mask A alt of branch 1.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mska_q[1] <= `MSKA_RESET;
    end else if (we_maa) begin
      mska_q[1] <= w_maa;
    end
  end

  // Mask B alt of branch 0, in the upper half of the shared dword.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mskb_q[0] <= `MSKB_RESET;
    end else if (we_mskb) begin
      mskb_q[0] <= w_b0[15:0];
    end
  end

  // Mask B of branch 1, in the lower half of the shared dword.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mskb_q[1] <= `MSKB_RESET;
    end else if (we_mskb) begin
      mskb_q[1] <= w_b1[15:0];
    end
  end

  // Read answer strobe: high exactly one cycle after each read.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= cfg_rd;
    end
  end

  // Read data, held until the next read.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (cfg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // Read answer outputs straight from their registers.
  assign cfg_rdata  = rdata_q;
  assign cfg_rvalid = rvalid_q;

  // Loop indices of the two paths and of the x8 devices.
  genvar g;
  genvar d;
  generate
    for (g = 0; g < 2; g++) begin : gen_path
      // Path g serves channel g and branch g; branch 1 pairs mask A alt with mask B,
      // branch 0 pairs mask A with mask B alt, so software keeps both pairs alike.
      // Channel control fields of this channel.
      chan_mode_e c_mode;
      assign c_mode = chan_mode_e'(ctl_q[g][`CTL_EN_HI:`CTL_EN_LO]);
      wire       c_sel   = ctl_q[g][`CTL_SEL_BIT];
      wire [2:0] c_cmd   = ctl_q[g][`CTL_CMD_HI:`CTL_CMD_LO];
      wire [3:0] c_op    = ctl_q[g][`CTL_OP_HI:`CTL_OP_LO];
      wire [3:0] c_flit  = ctl_q[g][`CTL_FLIT_HI:`CTL_FLIT_LO];
      wire [9:0] c_bits  = ctl_q[g][`CTL_BITS_HI:`CTL_BITS_LO];
      wire [3:0] c_lane  = stuck_q[g][`STUCK_HI:`STUCK_LO];

      // Trigger: the select bit picks which response function arms the injection.
      wire c_trig     = c_sel ? chan_in[g].resp_b : chan_in[g].resp_a;

      // Command match: 000 compares the opcode, 001 to 011 the command kind.
      // Reserved kinds 100 to 111 never match, so they inject nothing.
      wire c_by_op    = c_cmd == CMD_BY_OPCODE;
      wire c_op_hit   = chan_in[g].opcode == c_op;
      wire c_kind_ok  = c_cmd == CMD_PRE_ALL || c_cmd == CMD_READ || c_cmd == CMD_WRITE;
      wire c_kind_hit = c_kind_ok && (chan_in[g].cmd_kind == c_cmd);
      wire c_cmd_hit  = c_by_op ? c_op_hit : c_kind_hit;

      // Flit match: reserved flit numbers 12 to 15 never match.
      wire c_flt_ok   = c_flit <= `FLIT_LAST;
      wire c_flt_hit  = c_flt_ok && (chan_in[g].flit_idx == c_flit);

      // Flit corruption flips the programmed bit positions of one beat.
      wire c_mode_flt = c_mode == CH_INJ_FLIT;
      wire c_flip     = c_mode_flt && chan_in[g].valid && c_trig && c_cmd_hit && c_flt_hit;
      wire [9:0] c_xor   = c_flip ? c_bits : 10'h000;

      // Stuck mode forces one lane high on every cycle, idle or not.
      // Lane numbers above nine leave all lanes alone, as after reset.
      wire c_mode_stk = c_mode == CH_INJ_STUCK;
      wire c_lane_ok  = c_lane <= `STUCK_LAST_LANE;
      wire c_stuck    = c_mode_stk && c_lane_ok;
      wire [9:0] c_or    = c_stuck ? (10'h001 << c_lane) : 10'h000;

      // Lanes leaving towards the buffer.
      wire [9:0] c_lanes = (chan_in[g].lanes ^ c_xor) | c_or;

      // Memory mask fields of this branch; branch 1 pairs mask A alt with mask B.
      half_sel_e m_half;
      assign m_half = half_sel_e'(mska_q[g][`MSKA_HALF_HI:`MSKA_HALF_LO]);
      wire       m_en    = mska_q[g][`MSKA_EN_BIT];
      wire       m_sel   = mska_q[g][`MSKA_SEL_BIT];
      wire [4:0] m_pos1  = mska_q[g][`MSKA_POS1_HI:`MSKA_POS1_LO];
      wire [4:0] m_pos2  = mska_q[g][`MSKA_POS2_HI:`MSKA_POS2_LO];
      wire       ph2     = mem_in[g].phase;
      wire [7:0] m_byte1 = ph2 ? mska_q[g][`MSKA_PH2_HI:`MSKA_PH2_LO]
                               : mska_q[g][`MSKA_PH1_HI:`MSKA_PH1_LO];
      wire [7:0] m_byte2 = ph2 ? mskb_q[g][`MSKB_PH2_HI:`MSKB_PH2_LO]
                               : mskb_q[g][`MSKB_PH1_HI:`MSKB_PH1_LO];

      // Trigger: the function-select bit picks which response arms the injection.
      wire m_trig   = m_sel ? mem_in[g].resp_b : mem_in[g].resp_a;

      // Half-line window: transfers 0 and 1 are the lower half, 2 and 3 the upper.
      // Code 00 is reserved and opens no window.
      wire m_upper  = mem_in[g].xfer[1];
      wire m_lo_hit = (m_half == HALF_LOWER) && !m_upper;
      wire m_hi_hit = (m_half == HALF_UPPER) && m_upper;
      wire m_all    = m_half == HALF_BOTH;
      wire m_half_hit = m_lo_hit || m_hi_hit || m_all;

      // Both masks act whenever injection is on; a zero mask, a position above 17 or a second location equal to the first is harmless.
      wire m_act  = m_en && mem_in[g].valid && m_trig && m_half_hit;

      // A second location equal to the first is dropped.
      wire m_use2 = m_pos2 != m_pos1;
      wire [143:0] m_xor;

      // Per-device mask lanes; positions 18 to 31 hit no device.
      for (d = 0; d < `DEV_COUNT; d++) begin : gen_dev
        wire hit1 = m_pos1 == 5'(d);
        wire hit2 = m_use2 && (m_pos2 == 5'(d));
        wire [7:0] x1 = hit1 ? m_byte1 : 8'h00;
        wire [7:0] x2 = hit2 ? m_byte2 : 8'h00;
        assign m_xor[d*8 +: 8] = m_act ? (x1 | x2) : 8'h00;
      end

      // Next output beats: all fields pass through, lanes and data carry the corruption.
      flit_s flit_d;
      beat_s beat_d;
      always_comb begin
        flit_d       = chan_in[g];
        flit_d.lanes = c_lanes;
      end
      always_comb begin
        beat_d      = mem_in[g];
        beat_d.data = mem_in[g].data ^ m_xor;
      end

      // Channel output register; reset shows an idle flit.
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          flit_q[g] <= '0;
        end else begin
          flit_q[g] <= flit_d;
        end
      end

      // Memory output register; reset shows an idle beat.
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          beat_q[g] <= '0;
        end else begin
          beat_q[g] <= beat_d;
        end
      end

      // Outputs come straight from the output registers.
      assign chan_out[g] = flit_q[g];
      assign mem_out[g]  = beat_q[g];
    end
  endgenerate

endmodule

// ==== bench/memory_channel_partner.sv ====
/*
  Far-side model of the memory channel and the DIMMs: it latches every beat that it receives.
  Assumes the outputs of the injection block, sampled on the core clock.
*/
`timescale 1ns/1ps
module memory_channel_partner
  import mem_inject_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire flit_s chan_rx   [2],
  input  wire beat_s mem_rx    [2],
  output flit_s      chan_seen [2],
  output beat_s      mem_seen  [2]
);
  // The buffer side takes each flit and each data phase on the edge after it leaves the block.
  always_ff @(posedge clk_sys) begin
    chan_seen <= chan_rx;
    mem_seen  <= mem_rx;
  end
endmodule

// ==== bench/memory_error_injection_properties.sv ====
/*
  Port checker of the memory error injection block.
  Assumes binding onto the top module, one core clock and an active-low reset.
*/
`timescale 1ns/1ps
module memory_error_injection_properties
  import mem_inject_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [11:0] cfg_addr,
  input wire logic        cfg_rd,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_rvalid,
  input wire flit_s       chan_in  [2],
  input wire flit_s       chan_out [2],
  input wire beat_s       mem_in   [2],
  input wire beat_s       mem_out  [2]
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // A stuck lane may only raise one lane; nothing else may change.
  function automatic logic only_stuck(logic [9:0] o, logic [9:0] i);
    return ((i & ~o) == 10'h000) && ($countones(o & ~i) <= 1);
  endfunction
  // Counts the x8 devices whose byte differs.
  function automatic int dev_hits(logic [143:0] o, logic [143:0] i);
    int n;
    n = 0;
    for (int k = 0; k < 18; k++) n += int'(o[8*k+:8] != i[8*k+:8]);
    return n;
  endfunction
  // Read request and its answer.
  sequence s_read; cfg_rd; endsequence
  sequence s_answer; cfg_rvalid; endsequence
  property p_read_answer; s_read |=> s_answer; endproperty
  property p_no_spurious; !cfg_rd |=> !cfg_rvalid; endproperty
  property p_rdata_hold; !cfg_rd |=> $stable(cfg_rdata); endproperty
  property p_unmapped;
    cfg_rd && !(cfg_addr[11:2] inside {10'h040, 10'h041, 10'h042, 10'h043, 10'h044, 10'h083, 10'h084})
      |=> cfg_rdata == 32'h0000_0000;
  endproperty
  property p_chan_fields; reset_n |=> chan_out[0][23:10] == $past(chan_in[0][23:10]); endproperty
  property p_idle_flit; !chan_in[0].valid |=> only_stuck(chan_out[0].lanes, $past(chan_in[0].lanes)); endproperty
  property p_rsvd_flit; chan_in[0].flit_idx > 4'hb |=> only_stuck(chan_out[0].lanes, $past(chan_in[0].lanes));
  endproperty
  property p_mem_idle; !mem_in[0].valid |=> mem_out[0].data == $past(mem_in[0].data); endproperty
  property p_mem_two; reset_n |=> dev_hits(mem_out[0].data, $past(mem_in[0].data)) <= 2; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered next cycle");
  a_no_spurious: assert property (p_no_spurious) else $error("answer without read");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_chan_fields: assert property (p_chan_fields) else $error("flit fields altered");
  a_idle_flit: assert property (p_idle_flit) else $error("idle flit corrupted");
  a_rsvd_flit: assert property (p_rsvd_flit) else $error("reserved flit number corrupted");
  a_mem_idle: assert property (p_mem_idle) else $error("idle beat corrupted");
  a_mem_two: assert property (p_mem_two) else $error("more than two devices corrupted");
endmodule

bind memory_error_injection memory_error_injection_properties memory_error_injection_properties_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
  .cfg_rvalid(cfg_rvalid), .chan_in(chan_in), .chan_out(chan_out), .mem_in(mem_in), .mem_out(mem_out)
);

// ==== bench/memory_error_injection_tb_top.sv ====
/*
  Self-checking bench of the memory error injection block with random traffic and settings.
  Assumes the design, the package, the register header and the far-side model.
*/
`timescale 1ns/1ps
module memory_error_injection_tb_top;
  import mem_inject_pkg::*;
  logic        clk_sys, reset_n, cfg_wr, cfg_rd, cfg_rvalid;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_be, stk;
  logic [31:0] cfg_wdata, cfg_rdata, ctl, ma;
  logic [15:0] mb;
  flit_s       chan_in [2], chan_out [2], chan_seen [2];
  beat_s       mem_in [2], mem_out [2], mem_seen [2];
  int          fail_count, n_checks;

  memory_error_injection memory_error_injection_inst (.clk_sys(clk_sys), .reset_n(reset_n), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .chan_in(chan_in), .chan_out(chan_out), .mem_in(mem_in), .mem_out(mem_out));
  memory_channel_partner memory_channel_partner_inst (.clk_sys(clk_sys), .chan_rx(chan_out), .mem_rx(mem_out),
    .chan_seen(chan_seen), .mem_seen(mem_seen));

  // Core clock of 8 ns.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Compares and reports one value.
  task automatic check(input logic [159:0] got, input logic [159:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic test_done;
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // One-cycle write and read strobes; both start and end just after a rising edge.
  task automatic cfg_write(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(posedge clk_sys);
    #1 cfg_wr = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic cfg_read(input logic [11:0] a, input logic [31:0] exp);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(posedge clk_sys);
    #1 cfg_rd = 1'b0;
    check(cfg_rvalid, 1'b1);
    check(cfg_rdata, exp);
    @(posedge clk_sys);
    #1;
  endtask
  function automatic logic [149:0] rnd150();
    logic [159:0] r;
    r = {$urandom, $urandom, $urandom, $urandom, $urandom};
    return r[149:0];
  endfunction
  // Expected lanes of a flit under control c and stuck lane s.
  function automatic flit_s chan_exp(flit_s f, logic [31:0] c, logic [3:0] s);
    logic [9:0] l;
    logic       hit;
    l = f.lanes;
    hit = (c[21] ? f.resp_b : f.resp_a) && f.valid && f.flit_idx == c[13:10] && c[13:10] <= 4'hb
      && (c[20:18] == 3'h0 ? f.opcode == c[17:14] : c[20:18] <= 3'h3 && f.cmd_kind == c[20:18]);
    if (c[23:22] == 2'h1 && hit) l = l ^ c[9:0];
    if (c[23:22] == 2'h2 && s <= 4'h9) l[s] = 1'b1;
    f.lanes = l;
    return f;
  endfunction
  // Expected data of a beat under mask A value a and mask B value m.
  function automatic beat_s mem_exp(beat_s b, logic [31:0] a, logic [15:0] m);
    logic [143:0] d;
    d = b.data;
    if (b.valid && a[27] && (a[26] ? b.resp_b : b.resp_a) && (b.xfer[1] ? a[29] : a[28])) begin
      if (a[4:0] < 5'h12) d[a[4:0]*8+:8] ^= b.phase ? a[25:18] : a[17:10];
      if (a[9:5] < 5'h12 && a[9:5] != a[4:0]) d[a[9:5]*8+:8] ^= b.phase ? m[15:8] : m[7:0];
    end
    b.data = d;
    return b;
  endfunction
  // Sends one flit and one beat per branch; hit sets valid, one of the two triggers, flit number and command kind, and the opcode for transfers 2 and 3.
  task automatic xfer(input logic [1:0] x, input logic hit);
    flit_s f [2];
    beat_s b [2];
    for (int p = 0; p < 2; p++) begin
      f[p] = flit_s'(24'($urandom));
      b[p] = beat_s'(rnd150());
      b[p].xfer = x;
      if (hit) begin
        f[p].valid = 1'b1;
        f[p].resp_b = ~f[p].resp_a;
        f[p].flit_idx = ctl[13:10];
        f[p].cmd_kind = ctl[20:18];
        if (x[1]) f[p].opcode = ctl[17:14];
        b[p].valid = 1'b1;
        b[p].resp_b = ~b[p].resp_a;
      end
      chan_in[p] = f[p];
      mem_in[p] = b[p];
    end
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
    check(chan_seen[0], chan_exp(f[0], ctl, stk));
    check(chan_seen[1], chan_exp(f[1], ctl, stk));
    check(mem_seen[0], mem_exp(b[0], ma, mb));
    check(mem_seen[1], mem_exp(b[1], ma, mb));
  endtask

  // Watchdog against a hang.
  initial begin
    #200000;
    fail_count++;
    test_done();
  end

  // Main sequence: reset values, reserved bits, then random settings with traffic.
  initial begin
    {reset_n, cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
    {chan_in[0], chan_in[1], mem_in[0], mem_in[1]} = '0;
    {fail_count, n_checks} = '0;
    void'($urandom(32'he19f));
    repeat (4) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    cfg_read(12'h10c, 32'h0000_0000);
    cfg_read(12'h111, 32'h0000_0f00);
    cfg_read(12'h211, 32'h0000_0f00);
    cfg_read(12'h108, 32'h1000_0000);
    cfg_write(12'h10c, 4'hf, 32'hffff_ffff);
    cfg_write(12'h300, 4'hf, 32'hffff_ffff);
    cfg_read(12'h10c, 32'h00ff_ffff);
    cfg_read(12'h300, 32'h0000_0000);
    for (int i = 0; i < 64; i++) begin
      ctl = {8'h00, 2'(i), 22'($urandom)};
      stk = 4'($urandom);
      ma = {2'h0, 30'($urandom)};
      ma[27] = (i % 4 != 0);
      if (i % 8 == 1) ma[9:5] = ma[4:0];
      mb = 16'($urandom);
      cfg_write(12'h10c, 4'hf, ctl);
      cfg_write(12'h111, 4'h2, {20'h00000, stk, 8'h00});
      cfg_write(12'h100, 4'hf, ma);
      cfg_write(12'h106, 4'hc, {mb, 16'h0000});
      cfg_write(12'h20c, 4'hf, ctl);
      cfg_write(12'h211, 4'h2, {20'h00000, stk, 8'h00});
      cfg_write(12'h108, 4'hf, ma);
      cfg_write(12'h104, 4'h3, {16'h0000, mb});
      cfg_read(12'h100, ma);
      cfg_read(12'h108, ma);
      cfg_read(12'h104, {mb, mb});
      for (int k = 0; k < 4; k++) xfer(2'(k), k % 2 == 1);
    end
    test_done();
  end
endmodule
